// ==== rtl/cis_regs.vh ====
// How it works
// - inputs 0-3 fixed: 0 reset, 1 non-maskable, 2 and 3 never driven
// - inputs 4-15 follow the source named by their selector field, rewritable anytime
// - low register fields for inputs 4-9, reset codes 4 to 9
// - high register fields for inputs 10-15, reset codes 3,10,11,0,1,2
// - codes 4-7 pick pin events 4-7, code 16 picks pin 0 event
// - code 8 picks the combined dma completion interrupt
// - codes 9, 10, 11 pick emulation transfer, receive and transmit events
// - code 3 wide memory refresh, codes 12-15 serial ports 0 and 1
// - codes 17,18 serial port 2, code 19 timer 2, code 20 narrow refresh
// - code 23 picks the cell interface interrupt on variants having it
// - codes 30 and 31 pick viterbi and turbo coprocessor interrupts
// - pins 4-7 also external interrupt sources, output drive off after reset
// - interrupt inputs prioritised by number, 0 highest, 15 lowest
`ifndef CIS_REGS_VH
`define CIS_REGS_VH

// byte offsets on the register bus
`define CIS_OFS_SEL_HIGH   4'h0
`define CIS_OFS_SEL_LOW    4'h4
`define CIS_OFS_STATUS     4'h8
`define CIS_OFS_PIN_CTRL   4'hc

`define CIS_SEL_LOW_RST    32'h250718a4
`define CIS_SEL_HIGH_RST   32'h08202d43
`define CIS_SEL_WMASK      32'h7fff7fff
`define CIS_FIELD_W        5
`define CIS_FIELDS_PER_REG 4'h6
`define CIS_FIRST_PROG     4'h4
`define CIS_PIN_CTRL_RST   8'h00

// source codes
`define CIS_C_HOST         5'h00
`define CIS_C_TIMER0       5'h01
`define CIS_C_TIMER1       5'h02
`define CIS_C_WIDE_REF     5'h03
`define CIS_C_PIN4         5'h04
`define CIS_C_PIN5         5'h05
`define CIS_C_PIN6         5'h06
`define CIS_C_PIN7         5'h07
`define CIS_C_DMA          5'h08
`define CIS_C_EMU_XFER     5'h09
`define CIS_C_EMU_RX       5'h0a
`define CIS_C_EMU_TX       5'h0b
`define CIS_C_S0_TX        5'h0c
`define CIS_C_S0_RX        5'h0d
`define CIS_C_S1_TX        5'h0e
`define CIS_C_S1_RX        5'h0f
`define CIS_C_PIN0         5'h10
`define CIS_C_S2_TX        5'h11
`define CIS_C_S2_RX        5'h12
`define CIS_C_TIMER2       5'h13
`define CIS_C_NARROW_REF   5'h14
`define CIS_C_CELL         5'h17
`define CIS_C_VITERBI      5'h1e
`define CIS_C_TURBO        5'h1f

`endif

// ==== rtl/cis_selector.v ====
// Chosen here: the placing of the registers and register access over Avalon-MM.
`include "cis_regs.vh"
`timescale 1ns/100ps
`default_nettype none

module cis_selector
#(
    parameter HAS_CELL_IF = 1,
    parameter HAS_COPROC  = 1
)
(
    input  wire        clk_i,
    input  wire        sys_rst_i,
    // avalon-mm slave
    input  wire [3:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output wire [31:0] avs_readdata_o,
    output wire        avs_waitrequest_o,
    // fixed core inputs
    input  wire        reset_event_i,
    input  wire        nmi_event_i,
    // peripheral event lines
    input  wire        host_irq_i,
    input  wire        timer_zero_irq_i,
    input  wire        timer_one_irq_i,
    input  wire        timer_two_irq_i,
    input  wire        wide_mem_refresh_irq_i,
    input  wire        narrow_mem_refresh_irq_i,
    input  wire        pin0_event_i,
    input  wire [3:0]  pin_in_i,
    input  wire        dma_completion_irq_i,
    input  wire        emulation_transfer_event_i,
    input  wire        emulation_rx_event_i,
    input  wire        emulation_tx_event_i,
    input  wire        serial0_tx_irq_i,
    input  wire        serial0_rx_irq_i,
    input  wire        serial1_tx_irq_i,
    input  wire        serial1_rx_irq_i,
    input  wire        serial2_tx_irq_i,
    input  wire        serial2_rx_irq_i,
    input  wire        cell_interface_irq_i,
    input  wire        viterbi_coproc_irq_i,
    input  wire        turbo_coproc_irq_i,
    // pins 4-7 drive side
    output wire [3:0]  pin_out_o,
    output wire [3:0]  pin_oe_o,
    // core side
    output wire [15:0] cpu_int_o,
    output wire [3:0]  top_int_o,
    output wire        top_valid_o
);

    reg  [31:0] sel_low_reg;
    reg  [31:0] sel_high_reg;
    reg  [7:0]  pin_ctrl_reg;
    reg  [15:0] cpu_int_reg;
    reg  [15:0] cpu_int_next;
    reg  [3:0]  top_int_reg;
    reg  [3:0]  top_int_next;
    reg         top_valid_reg;
    reg         top_valid_next;
    reg  [31:0] rdata_reg;
    reg  [31:0] rdata_next;
    reg         wait_reg;
    wire        wait_next;
    wire        req;
    wire        wr_take;
    wire [31:0] bmask;
    wire [31:0] src_vec;
    wire [11:0] prog_int;

    // field lsb inside its register; bit 15 is skipped
    function [4:0] field_lsb;
        input [3:0] k;
        begin
            if (k < 4'h3)
                field_lsb = k * 5'd5;
            else
                field_lsb = k * 5'd5 + 5'd1;
        end
    endfunction

    function pick_source;
        input [31:0] v;
        input [4:0]  code;
        begin
            pick_source = v[code];
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] wd;
        input [31:0] m;
        begin
            merge = (old & ~m) | (wd & m);
        end
    endfunction

    // reserved codes stay zero in the source vector, so they select nothing
    assign src_vec = {
        turbo_coproc_irq_i & (HAS_COPROC != 0),
        viterbi_coproc_irq_i & (HAS_COPROC != 0),
        6'h00,
        cell_interface_irq_i & (HAS_CELL_IF != 0),
        2'h0,
        narrow_mem_refresh_irq_i,
        timer_two_irq_i,
        serial2_rx_irq_i,
        serial2_tx_irq_i,
        pin0_event_i,
        serial1_rx_irq_i,
        serial1_tx_irq_i,
        serial0_rx_irq_i,
        serial0_tx_irq_i,
        emulation_tx_event_i,
        emulation_rx_event_i,
        emulation_transfer_event_i,
        dma_completion_irq_i,
        pin_in_i,
        wide_mem_refresh_irq_i,
        timer_one_irq_i,
        timer_zero_irq_i,
        host_irq_i
    };

    genvar gi;
    generate
        for (gi = 0; gi < 2 * `CIS_FIELDS_PER_REG; gi = gi + 1)
        begin : g_route
            localparam integer FK = gi % `CIS_FIELDS_PER_REG;
            wire [31:0] reg_word;
            wire [4:0]  lsb;
            wire [4:0]  code;
            assign reg_word = (gi < `CIS_FIELDS_PER_REG) ? sel_low_reg : sel_high_reg;
            assign lsb      = field_lsb(FK[3:0]);
            assign code     = reg_word[lsb +: `CIS_FIELD_W];
            assign prog_int[gi] = pick_source(src_vec, code);
        end
    endgenerate

    always @*
    begin
        cpu_int_next = {prog_int, 2'b00, nmi_event_i, reset_event_i};
    end

    // lowest index wins
    always @*
    begin : p_prio
        integer n;
        top_int_next   = 4'h0;
        top_valid_next = 1'b0;
        for (n = 15; n >= 0; n = n - 1)
        begin
            if (cpu_int_next[n])
            begin
                top_int_next   = n[3:0];
                top_valid_next = 1'b1;
            end
        end
    end

    // one wait cycle: request seen, then waitrequest low for a single cycle
    assign req       = avs_read_i | avs_write_i;
    assign wait_next = ~(req & wait_reg);
    assign wr_take   = avs_write_i & ~wait_reg;
    assign bmask     = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                        {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

    always @*
    begin
        case (avs_address_i)
            `CIS_OFS_SEL_HIGH: rdata_next = sel_high_reg;
            `CIS_OFS_SEL_LOW:  rdata_next = sel_low_reg;
            `CIS_OFS_STATUS:   rdata_next = {top_valid_reg, 11'h000, top_int_reg, cpu_int_reg};
            `CIS_OFS_PIN_CTRL: rdata_next = {24'h000000, pin_ctrl_reg};
            default:           rdata_next = 32'h00000000;
        endcase
    end

    always @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            wait_reg      <= 1'b1;
            rdata_reg     <= 32'h00000000;
            sel_low_reg   <= `CIS_SEL_LOW_RST;
            sel_high_reg  <= `CIS_SEL_HIGH_RST;
            pin_ctrl_reg  <= `CIS_PIN_CTRL_RST;
            cpu_int_reg   <= 16'h0000;
            top_int_reg   <= 4'h0;
            top_valid_reg <= 1'b0;
        end
        else
        begin
            wait_reg      <= wait_next;
            cpu_int_reg   <= cpu_int_next;
            top_int_reg   <= top_int_next;
            top_valid_reg <= top_valid_next;
            if (req & wait_reg)
                rdata_reg <= avs_read_i ? rdata_next : 32'h00000000;
            if (wr_take)
            begin
                case (avs_address_i)
                    `CIS_OFS_SEL_HIGH:
                        sel_high_reg <= merge(sel_high_reg, avs_writedata_i,
                                              bmask & `CIS_SEL_WMASK);
                    `CIS_OFS_SEL_LOW:
                        sel_low_reg <= merge(sel_low_reg, avs_writedata_i,
                                             bmask & `CIS_SEL_WMASK);
                    `CIS_OFS_PIN_CTRL:
                        if (avs_byteenable_i[0])
                            pin_ctrl_reg <= avs_writedata_i[7:0];
                    default:
                        ;
                endcase
            end
        end
    end

    assign avs_waitrequest_o = wait_reg;
    assign avs_readdata_o    = rdata_reg;
    assign pin_oe_o          = pin_ctrl_reg[3:0];
    assign pin_out_o         = pin_ctrl_reg[7:4];
    assign cpu_int_o         = cpu_int_reg;
    assign top_int_o         = top_int_reg;
    assign top_valid_o       = top_valid_reg;

endmodule

`default_nettype wire

// ==== testbench/cis_event_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module cis_event_model (
    input  wire logic [4:0]  code_i,
    input  wire logic        on_i,
    output logic      [31:0] src_o
);
    // one peripheral line per source code, raised as a level
    // reserved codes have no line wired behind them
    always_comb
    begin
        src_o = 32'h0;
        if (on_i)
            src_o[code_i] = 1'b1;
    end
endmodule
`default_nettype wire

// ==== testbench/cis_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module cis_monitor (
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic [3:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        reset_event_i,
    input wire logic        nmi_event_i,
    input wire logic [3:0]  pin_oe_o,
    input wire logic [15:0] cpu_int_o,
    input wire logic [3:0]  top_int_o,
    input wire logic        top_valid_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic pin_wr_reg;
    always_ff @(posedge clk_i or posedge sys_rst_i)
        if (sys_rst_i)
            pin_wr_reg <= 1'b0;
        else if (avs_write_i && !avs_waitrequest_o && avs_address_i == 4'hc)
            pin_wr_reg <= 1'b1;
    chk_fixed_low: assert property (cpu_int_o[3:2] == 2'b00)
        else $error("fixed inputs 2 and 3 driven");
    chk_reset_follow: assert property (cpu_int_o[0] == $past(reset_event_i))
        else $error("reset input not passed through");
    chk_nmi_follow: assert property ($rose(nmi_event_i) |=> $rose(cpu_int_o[1]))
        else $error("nmi input not passed through");
    chk_req_answer: assert property ($rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
        else $error("bus request not answered");
    chk_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    chk_top_valid: assert property (top_valid_o == |cpu_int_o)
        else $error("top valid wrong");
    chk_top_lowest: assert property (top_valid_o |-> cpu_int_o[top_int_o] &&
        ((cpu_int_o & ((16'h1 << top_int_o) - 16'h1)) == 16'h0))
        else $error("top index not lowest");
    chk_rsvd_bits: assert property (avs_read_i && !avs_waitrequest_o && !avs_address_i[3]
        |-> {avs_readdata_o[31], avs_readdata_o[15]} == 2'b00)
        else $error("unused select bits read nonzero");
    chk_oe_idle: assert property (!pin_wr_reg |-> pin_oe_o == 4'h0)
        else $error("pin drive enabled without write");
endmodule
bind cis_selector cis_monitor u_mon (.clk_i, .sys_rst_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .reset_event_i, .nmi_event_i,
    .pin_oe_o, .cpu_int_o, .top_int_o, .top_valid_o);
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        clk_i = 0, sys_rst_i = 1, rd = 0, wr = 0, rst_ev = 0, nmi_ev = 0, on = 0;
    logic [3:0]  adr = 0;
    logic [4:0]  code = 0, cc;
    logic [31:0] wd = 0, rdat, q, src;
    logic [4:0]  dflt [12] = '{5'h4, 5'h5, 5'h6, 5'h7, 5'h8, 5'h9, 5'h3, 5'ha, 5'hb, 5'h0, 5'h1, 5'h2};
    wire  [15:0] ci;
    wire  [3:0]  ti, oe, po;
    wire         tv, wrq;
    int          err_count = 0, total_checks = 0;
    always #10 clk_i = ~clk_i;
    cis_event_model model (.code_i(code), .on_i(on), .src_o(src));
    cis_selector dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wrq), .reset_event_i(rst_ev),
        .nmi_event_i(nmi_ev), .host_irq_i(src[0]), .timer_zero_irq_i(src[1]),
        .timer_one_irq_i(src[2]), .timer_two_irq_i(src[19]), .wide_mem_refresh_irq_i(src[3]),
        .narrow_mem_refresh_irq_i(src[20]), .pin0_event_i(src[16]), .pin_in_i(src[7:4]),
        .dma_completion_irq_i(src[8]), .emulation_transfer_event_i(src[9]),
        .emulation_rx_event_i(src[10]), .emulation_tx_event_i(src[11]),
        .serial0_tx_irq_i(src[12]), .serial0_rx_irq_i(src[13]), .serial1_tx_irq_i(src[14]),
        .serial1_rx_irq_i(src[15]), .serial2_tx_irq_i(src[17]), .serial2_rx_irq_i(src[18]),
        .cell_interface_irq_i(src[23]), .viterbi_coproc_irq_i(src[30]),
        .turbo_coproc_irq_i(src[31]), .pin_out_o(po), .pin_oe_o(oe), .cpu_int_o(ci),
        .top_int_o(ti), .top_valid_o(tv));
    function automatic logic [31:0] pk(input logic [4:0] a, b, c, d, e, f);
        pk = {1'b0, f, e, d, 1'b0, c, b, a};
    endfunction
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, e);
        total_checks++;
        if (s !== e)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    // hold the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        adr <= a; wr <= w; rd <= !w; wd <= d;
        i = 0;
        do
        begin
            @(posedge clk_i);
            i++;
        end while (wrq !== 1'b0 && i < 50);
        if (wrq !== 1'b0)
            err_count++;
        q = rdat;
        rd <= 0; wr <= 0;
    endtask
    task automatic drive(input logic [4:0] c, input logic o);
        @(posedge clk_i);
        code <= c; on <= o;
        repeat (2) @(negedge clk_i);
    endtask
    initial
    begin
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 0;
        bus(0, 4'h4, 0); chk("low select", q, pk(5'h4, 5'h5, 5'h6, 5'h7, 5'h8, 5'h9));
        bus(0, 4'h0, 0); chk("high select", q, pk(5'h3, 5'ha, 5'hb, 5'h0, 5'h1, 5'h2));
        bus(0, 4'hc, 0); chk("pin control", q, 0);
        chk("pin oe", oe, 0);
        $display("test reset values done");
        for (int k = 0; k < 12; k++)
        begin
            drive(dflt[k], 1); chk("default route", ci[15:4], 12'h1 << k);
        end
        @(posedge clk_i) nmi_ev <= 1;
        drive(5'h4, 1); chk("fixed inputs", ci[3:0], 4'h2);
        chk("top", {tv, ti}, 5'h11);
        @(posedge clk_i) rst_ev <= 1;
        drive(5'h4, 0); chk("top reset", {tv, ti, ci[3:0]}, 9'h103);
        @(posedge clk_i) {rst_ev, nmi_ev} <= 2'b00;
        $display("test fixed and priority done");
        for (int c = 0; c < 32; c++)
        begin
            cc = c[4:0];
            bus(1, 4'h4, pk(cc, cc, cc, cc, cc, cc));
            drive(cc, 1);
            chk("sweep", ci[9:4], (c == 21 || c == 22 || (c > 23 && c < 30)) ? 0 : 6'h3f);
            drive(cc, 0); chk("sweep idle", ci[9:4], 0);
        end
        $display("test code sweep done");
        bus(1, 4'h4, 32'hffffffff); bus(0, 4'h4, 0); chk("unused bits", q, 32'h7fff7fff);
        bus(1, 4'h1, 32'hffffffff); bus(0, 4'h1, 0); chk("unmapped", q, 0);
        bus(1, 4'hc, 32'h000000a5); bus(0, 4'hc, 0); chk("pin rw", q, 32'ha5);
        chk("pin oe set", oe, 4'h5);
        chk("pin out", po, 4'ha);
        $display("test bus refusals done");
        summarize;
    end
    initial
    begin
        #400000;
        err_count++;
        summarize;
    end
endmodule
`default_nettype wire
